// File: logic/atl_pkg.sv
package atl_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // bus and register map
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFF_CTRL0 = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CTRL1 = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CTRL2 = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_DELAY = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_RES_HIGH = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_RES_LOW = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_LOW_LIM_HIGH = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_LOW_LIM_LOW = 8'h1c;
    localparam logic [ADDR_W-1:0] OFF_HIGH_LIM_HIGH = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_HIGH_LIM_LOW = 8'h24;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h28;
    localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 8'h2c;

    ////////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int C0_START = 7;
    localparam int C0_BUSY = 6;
    localparam int C0_POWER_OFF = 5;
    localparam int C0_ALIGN = 4;
    localparam int CH_W = 4;
    localparam int C1_TRIG_SEL = 7;
    localparam int C1_DELAY_EN = 6;
    localparam int C1_PWM_SRC = 5;
    localparam int C1_UPPER = 4;
    localparam int C1_LOWER = 3;
    localparam int DIV_W = 3;
    localparam int DUTY_W = 2;
    localparam int ST_CONV = 0;
    localparam int ST_LIMIT = 1;

    ////////////////////////////////////////////////////////////////////////////////
    // reset values and counts
    localparam logic RST_BUSY = 1'b1;
    localparam logic RST_POWER_OFF = 1'b1;
    localparam logic [4:0] CONV_TICKS = 5'd16;
    localparam logic [1:0] DUTY_CH2 = 2'b10;

    typedef enum logic [1:0] {
        ATL_IDLE = 2'b00,
        ATL_DELAY = 2'b01,
        ATL_CONV = 2'b10
    } atl_state_e;

    ////////////////////////////////////////////////////////////////////////////////
    // data layout helpers
    function automatic logic [11:0] limitValue(input logic [7:0] hi, input logic [7:0] lo,
                                               input logic align);
        return align ? {hi[3:0], lo} : {hi, lo[7:4]};
    endfunction

    function automatic logic [7:0] fmtHigh(input logic [11:0] v, input logic align);
        return align ? {4'h0, v[11:8]} : v[11:4];
    endfunction

    function automatic logic [7:0] fmtLow(input logic [11:0] v, input logic align);
        return align ? v[7:0] : {v[3:0], 4'h0};
    endfunction

    function automatic logic [5:0] divMask(input logic [DIV_W-1:0] sel);
        logic [5:0] m;
        m = 6'h3f;
        case (sel)
            3'h0: m = 6'h00;
            3'h1: m = 6'h01;
            3'h2: m = 6'h03;
            3'h3: m = 6'h07;
            3'h4: m = 6'h0f;
            3'h5: m = 6'h1f;
            default: m = 6'h3f;
        endcase
        return m;
    endfunction

endpackage

// File: logic/atl_cmp_if.sv
`timescale 1ns/10ps
interface atl_cmp_if;
    logic [11:0] result;
    logic [11:0] lowLimit;
    logic [11:0] highLimit;
    logic upperMode;
    logic lowerMode;
    logic hit;
    modport owner (output result, lowLimit, highLimit, upperMode, lowerMode, input hit);
    modport cmp (input result, lowLimit, highLimit, upperMode, lowerMode, output hit);
endinterface

// File: logic/atl_limit_cmp.sv
`timescale 1ns/10ps
module atl_limit_cmp
    import atl_pkg::*;
(
    atl_cmp_if.cmp bus
);
    logic atLow;
    logic atHigh;

    always_comb begin
        atLow = bus.result <= bus.lowLimit;
        atHigh = bus.result >= bus.highLimit;
        unique case ({bus.upperMode, bus.lowerMode})
            2'b00: bus.hit = !atLow && !atHigh;
            2'b01: bus.hit = atLow;
            2'b10: bus.hit = atHigh;
            2'b11: bus.hit = atLow || atHigh;
        endcase
    end
endmodule // atl_limit_cmp

// File: logic/atl_clk_div.sv
`timescale 1ns/10ps
module atl_clk_div
    import atl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic restart,
    input wire logic [DIV_W-1:0] divSel,
    output logic tick
);
    typedef struct packed {
        logic [5:0] cnt;
        logic tick;
    } atl_div_s;

    atl_div_s s;
    atl_div_s next_s;

    always_comb begin
        next_s = s;
        // restart aligns the first converter period to the conversion start
        if (restart) begin
            next_s.cnt = 6'h00;
            next_s.tick = 1'b0;
        end else begin
            next_s.tick = (s.cnt & divMask(divSel)) == divMask(divSel);
            next_s.cnt = s.cnt + 6'h01;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick = s.tick;
endmodule // atl_clk_div

// File: logic/atl_top.sv
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/10ps
module atl_top
    import atl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pwmPeriodEvt,
    input wire logic [2:0] pwmDutyEvt,
    input wire logic [11:0] convResult,
    output logic adcReset,
    output logic adcPowerDown,
    output logic [CH_W-1:0] adcChannel,
    output logic adcClkEn,
    output logic adcStartPulse,
    output logic convIrq,
    output logic limitIrq
);
    typedef struct packed {
        atl_state_e fsm;
        logic startBit;
        logic prevStart;
        logic busy;
        logic powerOff;
        logic align;
        logic [CH_W-1:0] chan;
        logic trigSel;
        logic delayEn;
        logic pwmSrc;
        logic upperMode;
        logic lowerMode;
        logic [DIV_W-1:0] divSel;
        logic [DUTY_W-1:0] dutySel;
        logic [7:0] delayCnt;
        logic [7:0] delayLeft;
        logic [11:0] result;
        logic [7:0] lowHi;
        logic [7:0] lowLo;
        logic [7:0] highHi;
        logic [7:0] highLo;
        logic [4:0] tickCnt;
        logic convFlag;
        logic limitFlag;
        logic convIrqEn;
        logic limitIrqEn;
        logic convIrq;
        logic limitIrq;
        logic adcReset;
        logic clkEn;
        logic startPulse;
        logic [DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
    } atl_top_s;

    atl_top_s s;
    atl_top_s next_s;
    logic divTick;
    logic divRestart;
    logic pwmEvt;
    logic swStart;
    logic startNow;
    logic accessWr;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic mapped;

    atl_cmp_if cmpBus ();

    ////////////////////////////////////////////////////////////////////////////////
    // submodules

    atl_clk_div u_div (
        .clk(clk),
        .rst(rst),
        .restart(divRestart),
        .divSel(s.divSel),
        .tick(divTick)
    );

    atl_limit_cmp u_cmp (
        .bus(cmpBus)
    );

    // limits are assembled from the current layout, so changing the alignment
    // reinterprets bytes already written
    assign cmpBus.result = convResult;
    assign cmpBus.lowLimit = limitValue(s.lowHi, s.lowLo, s.align);
    assign cmpBus.highLimit = limitValue(s.highHi, s.highLo, s.align);
    assign cmpBus.upperMode = s.upperMode;
    assign cmpBus.lowerMode = s.lowerMode;

    ////////////////////////////////////////////////////////////////////////////////
    // register read decode

    always_comb begin
        mapped = 1'b1;
        rbyte = 8'h00;
        unique case (paddr)
            OFF_CTRL0: rbyte = {s.startBit, s.busy, s.powerOff, s.align, s.chan};
            OFF_CTRL1: rbyte = {s.trigSel, s.delayEn, s.pwmSrc, s.upperMode, s.lowerMode,
                                s.divSel};
            OFF_CTRL2: rbyte = {6'h00, s.dutySel};
            OFF_DELAY: rbyte = s.delayCnt;
            OFF_RES_HIGH: rbyte = fmtHigh(s.result, s.align);
            OFF_RES_LOW: rbyte = fmtLow(s.result, s.align);
            OFF_LOW_LIM_HIGH: rbyte = fmtHigh(cmpBus.lowLimit, s.align);
            OFF_LOW_LIM_LOW: rbyte = fmtLow(cmpBus.lowLimit, s.align);
            OFF_HIGH_LIM_HIGH: rbyte = fmtHigh(cmpBus.highLimit, s.align);
            OFF_HIGH_LIM_LOW: rbyte = fmtLow(cmpBus.highLimit, s.align);
            OFF_STATUS: rbyte = {6'h00, s.limitFlag, s.convFlag};
            OFF_IRQ_EN: rbyte = {6'h00, s.limitIrqEn, s.convIrqEn};
            default: mapped = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // trigger selection

    always_comb begin
        if (!s.pwmSrc) begin
            pwmEvt = pwmPeriodEvt;
        end else begin
            unique case (s.dutySel)
                2'b00: pwmEvt = pwmDutyEvt[0];
                2'b01: pwmEvt = pwmDutyEvt[1];
                2'b10: pwmEvt = pwmDutyEvt[DUTY_CH2];
                2'b11: pwmEvt = pwmDutyEvt[DUTY_CH2];
            endcase
        end
    end

    assign swStart = !s.trigSel && s.prevStart && !s.startBit;
    assign accessWr = psel && penable && s.pready && pwrite && !s.pslverr;
    assign wbyte = pwdata[7:0];

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next_s = s;
        startNow = 1'b0;
        next_s.pready = 1'b0;
        next_s.pslverr = 1'b0;
        next_s.clkEn = 1'b0;
        next_s.startPulse = 1'b0;
        next_s.prevStart = s.startBit;

        // one wait-free access phase; read data captured in the setup cycle
        if (psel && !penable) begin
            next_s.pready = 1'b1;
            next_s.pslverr = !mapped;
            next_s.prdata = {24'h000000, rbyte};
        end

        if (accessWr) begin
            unique case (paddr)
                OFF_CTRL0: begin
                    next_s.startBit = wbyte[C0_START];
                    next_s.powerOff = wbyte[C0_POWER_OFF];
                    next_s.align = wbyte[C0_ALIGN];
                    next_s.chan = wbyte[CH_W-1:0];
                end
                OFF_CTRL1: begin
                    next_s.trigSel = wbyte[C1_TRIG_SEL];
                    next_s.delayEn = wbyte[C1_DELAY_EN];
                    next_s.pwmSrc = wbyte[C1_PWM_SRC];
                    next_s.upperMode = wbyte[C1_UPPER];
                    next_s.lowerMode = wbyte[C1_LOWER];
                    next_s.divSel = wbyte[DIV_W-1:0];
                end
                OFF_CTRL2: next_s.dutySel = wbyte[DUTY_W-1:0];
                OFF_DELAY: next_s.delayCnt = wbyte;
                OFF_LOW_LIM_HIGH: next_s.lowHi = wbyte;
                OFF_LOW_LIM_LOW: next_s.lowLo = wbyte;
                OFF_HIGH_LIM_HIGH: next_s.highHi = wbyte;
                OFF_HIGH_LIM_LOW: next_s.highLo = wbyte;
                OFF_STATUS: begin
                    next_s.convFlag = s.convFlag && !wbyte[ST_CONV];
                    next_s.limitFlag = s.limitFlag && !wbyte[ST_LIMIT];
                end
                OFF_IRQ_EN: begin
                    next_s.convIrqEn = wbyte[ST_CONV];
                    next_s.limitIrqEn = wbyte[ST_LIMIT];
                end
                default: begin
                end
            endcase
        end

        unique case (s.fsm)
            ATL_IDLE: begin
                if (!s.powerOff) begin
                    if (swStart) begin
                        startNow = 1'b1;
                    end else if (s.trigSel && pwmEvt) begin
                        // a zero count with delay on starts at once instead of hanging
                        if (s.delayEn && s.delayCnt != 8'h00) begin
                            next_s.fsm = ATL_DELAY;
                            next_s.delayLeft = s.delayCnt;
                        end else begin
                            startNow = 1'b1;
                        end
                    end
                end
            end
            ATL_DELAY: begin
                if (s.delayLeft == 8'h01) begin
                    startNow = 1'b1;
                end else begin
                    next_s.delayLeft = s.delayLeft - 8'h01;
                end
            end
            ATL_CONV: begin
                next_s.clkEn = divTick;
                if (divTick) begin
                    next_s.tickCnt = s.tickCnt + 5'd1;
                    if (s.tickCnt == CONV_TICKS - 5'd1) begin
                        next_s.fsm = ATL_IDLE;
                        next_s.busy = 1'b0;
                        next_s.result = convResult;
                        next_s.convFlag = 1'b1;
                        if (cmpBus.hit) begin
                            next_s.limitFlag = 1'b1;
                        end
                    end
                end
            end
            default: next_s.fsm = ATL_IDLE;
        endcase

        if (startNow) begin
            next_s.fsm = ATL_CONV;
            next_s.busy = 1'b1;
            next_s.tickCnt = 5'd0;
            next_s.startPulse = 1'b1;
        end

        // powering down abandons any conversion; busy stays as it was
        if (s.powerOff) begin
            next_s.fsm = ATL_IDLE;
        end

        // a held start bit overrides everything on the software path
        next_s.adcReset = s.startBit && !s.trigSel;
        if (s.startBit && !s.trigSel) begin
            next_s.busy = 1'b1;
            next_s.fsm = ATL_IDLE;
        end

        next_s.convIrq = next_s.convFlag && next_s.convIrqEn;
        next_s.limitIrq = next_s.limitFlag && next_s.limitIrqEn;
    end

    assign divRestart = startNow;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.fsm <= ATL_IDLE;
            s.busy <= RST_BUSY;
            s.powerOff <= RST_POWER_OFF;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign adcReset = s.adcReset;
    assign adcPowerDown = s.powerOff;
    assign adcChannel = s.chan;
    assign adcClkEn = s.clkEn;
    assign adcStartPulse = s.startPulse;
    assign convIrq = s.convIrq;
    assign limitIrq = s.limitIrq;
endmodule // atl_top

// File: test/atl_top_props.sv
`timescale 1ns/10ps
module atl_top_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic adcReset,
    input wire logic adcPowerDown,
    input wire logic adcClkEn,
    input wire logic adcStartPulse,
    input wire logic convIrq,
    input wire logic limitIrq
);
    logic [4:0] tickCnt;

    ////////////////////////////////////////////////////////////////////////////////
    // 16 means idle; a power-off abort is counted as idle too
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tickCnt <= 5'h10;
        end else if (adcStartPulse) begin
            tickCnt <= 5'h00;
        end else if (adcPowerDown) begin
            tickCnt <= 5'h10;
        end else if (adcClkEn) begin
            tickCnt <= tickCnt + 5'h01;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////////
    start_once_a: assert property (adcStartPulse |=> !adcStartPulse)
        else $error("start pulse longer than one cycle");
    start_idle_a: assert property (adcStartPulse |-> tickCnt == 5'h10)
        else $error("start while converting");
    tick_bound_a: assert property (adcClkEn |-> tickCnt < 5'h10)
        else $error("converter tick after sixteenth");
    reset_quiet_a: assert property (adcReset |-> !adcStartPulse && !adcClkEn)
        else $error("converter active while held in reset");
    power_off_quiet_a: assert property (adcPowerDown && $past(adcPowerDown) |->
        !adcStartPulse && !adcClkEn)
        else $error("converter active while powered off");
    // flags and interrupt outputs are loaded on the same edge as the last tick
    conv_irq_end_a: assert property ($rose(convIrq) |-> adcClkEn)
        else $error("conversion interrupt not with last tick");
    limit_irq_end_a: assert property ($rose(limitIrq) |-> adcClkEn)
        else $error("limit interrupt not with last tick");
    pready_once_a: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("register access not answered in one cycle");
endmodule // atl_top_props

bind atl_top atl_top_props i_atl_top_props (.clk, .rst, .psel, .penable, .pready, .adcReset,
    .adcPowerDown, .adcClkEn, .adcStartPulse, .convIrq, .limitIrq);

// File: test/atl_pwm_model.sv
`timescale 1ns/10ps
module atl_pwm_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic fire,
    input wire logic [2:0] evSel,
    input wire logic [11:0] sample,
    output logic pwmPeriodEvt,
    output logic [2:0] pwmDutyEvt,
    output logic [11:0] convResult
);
    // events are one-cycle pulses; the result follows sample on every clock, one cycle late
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pwmPeriodEvt <= 1'b0;
            pwmDutyEvt <= 3'h0;
            convResult <= 12'h000;
        end else begin
            pwmPeriodEvt <= fire && evSel == 3'h0;
            pwmDutyEvt <= {fire && evSel == 3'h3, fire && evSel == 3'h2, fire && evSel == 3'h1};
            convResult <= sample;
        end
    end
endmodule // atl_pwm_model

// File: test/atl_top_tb.sv
`timescale 1ns/10ps
module atl_top_tb
    import atl_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic [DATA_W-1:0] pwdata = 32'h0;
    logic [DATA_W-1:0] prdata, rdata;
    logic pready, pslverr, rerr, pwmPeriodEvt;
    logic [2:0] pwmDutyEvt;
    logic [11:0] convResult;
    logic [CH_W-1:0] adcChannel;
    logic adcReset, adcPowerDown, adcClkEn, adcStartPulse, convIrq, limitIrq;
    logic fire = 1'b0;
    logic [2:0] evSel = 3'h0;
    logic [11:0] sample = 12'h000;
    int fail_count = 0;
    int total_checks = 0;

    always #12.5 clk = ~clk;

    atl_top i_atl_top (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .pwmPeriodEvt, .pwmDutyEvt, .convResult, .adcReset,
        .adcPowerDown, .adcChannel, .adcClkEn, .adcStartPulse, .convIrq, .limitIrq);
    atl_pwm_model i_atl_pwm_model (.clk, .rst, .fire, .evSel, .sample, .pwmPeriodEvt,
        .pwmDutyEvt, .convResult);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chkB(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chkB(pready, 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdata, e);
    endtask

    function automatic logic [7:0] hiB(input int v, input int al);
        return al ? 8'(v >> 8) : 8'(v >> 4);
    endfunction

    function automatic logic [7:0] loB(input int v, input int al);
        return al ? 8'(v) : 8'(v << 4);
    endfunction

    function automatic logic hitExp(input int m, input int r, input int lo, input int hi);
        case (m)
            0: return lo < r && r < hi;
            1: return r <= lo;
            2: return r >= hi;
            default: return r <= lo || r >= hi;
        endcase
    endfunction

    task automatic setLim(input int lo, input int hi, input int al);
        wr(OFF_LOW_LIM_HIGH, hiB(lo, al));
        wr(OFF_LOW_LIM_LOW, loB(lo, al));
        wr(OFF_HIGH_LIM_HIGH, hiB(hi, al));
        wr(OFF_HIGH_LIM_LOW, loB(hi, al));
        rd(OFF_HIGH_LIM_LOW, {24'h0, loB(hi, al)});
        rd(OFF_LOW_LIM_HIGH, {24'h0, hiB(lo, al)});
    endtask

    task automatic waitStart(output int t);
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (adcStartPulse !== 1'b1 && t < 40);
    endtask

    // fire one event; t counts edges from its arrival to the start pulse
    task automatic evStart(input logic [2:0] s, output int t);
        @(posedge clk);
        fire <= 1'b1;
        evSel <= s;
        @(posedge clk);
        fire <= 1'b0;
        @(posedge clk);
        waitStart(t);
    endtask

    // model of one conversion from its start pulse on
    task automatic waitConv(input int d, input int m, input int r, input int lo, input int hi);
        int t, n, last;
        t = 0;
        n = 0;
        last = 0;
        while (n < 16 && t < 3000) begin
            @(posedge clk);
            t++;
            if (adcClkEn === 1'b1) begin
                if (n > 0) chk(32'(t - last), 32'(1 << d));
                last = t;
                n++;
            end
        end
        chk(32'(n), 32'h10);
        repeat (3) @(posedge clk);
        chkB(convIrq, 1'b1);
        chkB(limitIrq, hitExp(m, r, lo, hi));
        rd(OFF_STATUS, {30'h0, hitExp(m, r, lo, hi), 1'b1});
        apb(1'b0, OFF_CTRL0, 32'h0);
        chkB(rdata[C0_BUSY], 1'b0);
        wr(OFF_STATUS, 8'h03);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #500000;
        fail_count++;
        end_sim();
    end

    initial begin
        int lo, hi, r, m, d, al, t;
        void'($urandom(32'hec744f5b));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(OFF_CTRL0, 32'h60);
        chkB(adcPowerDown, 1'b1);
        rd(OFF_CTRL1, 32'h0);
        rd(OFF_LOW_LIM_HIGH, 32'h0);
        apb(1'b0, 8'h30, 32'h0);
        chkB(rerr, 1'b1);
        chk(rdata, 32'h0);
        wr(OFF_IRQ_EN, 8'h03);
        $display("reset and map test done");
        for (int i = 0; i < 8; i++) begin
            m = i % 4;
            d = i % 7;
            al = i % 2;
            lo = $urandom_range(1200, 0);
            hi = $urandom_range(4095, 2800);
            r = (i < 2) ? lo : (i == 2 || i == 4) ? hi : $urandom_range(4095, 0);
            sample <= 12'(r);
            wr(OFF_CTRL1, 8'(m << 3 | d));
            // limit bytes read back through the current layout, so set it first
            wr(OFF_CTRL0, 8'(al << 4 | i));
            setLim(lo, hi, al);
            wr(OFF_CTRL0, 8'(8'h80 | al << 4 | i));
            repeat (2) @(posedge clk);
            chkB(adcReset, 1'b1);
            chk({28'h0, adcChannel}, 32'(i));
            apb(1'b0, OFF_CTRL0, 32'h0);
            chkB(rdata[C0_BUSY], 1'b1);
            wr(OFF_CTRL0, 8'(al << 4 | i));
            waitStart(t);
            chkB(adcStartPulse, 1'b1);
            chkB(adcPowerDown, 1'b0);
            waitConv(d, m, r, lo, hi);
            rd(OFF_RES_HIGH, {24'h0, hiB(r, al)});
            rd(OFF_RES_LOW, {24'h0, loB(r, al)});
        end
        $display("software start test done");
        wr(OFF_CTRL0, 8'h00);
        setLim(0, 4095, 0);
        for (int k = 0; k < 5; k++) begin
            r = 100 + k;
            sample <= 12'(r);
            wr(OFF_CTRL1, (k > 0) ? 8'he0 : 8'h80);
            wr(OFF_CTRL2, 8'(k - 1));
            wr(OFF_DELAY, 8'(3 * k));
            evStart((k == 0) ? 3'h1 : (k == 1) ? 3'h2 : 3'h0, t);
            chk(32'(t), 32'd40);
            evStart((k == 4) ? 3'h3 : 3'(k), t);
            chk(32'(t), 32'(3 * k + 1));
            waitConv(0, 0, r, 0, 4095);
        end
        $display("pwm start test done");
        wr(OFF_CTRL1, 8'h00);
        wr(OFF_DELAY, 8'h00);
        evStart(3'h0, t);
        chk(32'(t), 32'd40);
        wr(OFF_CTRL0, 8'h20);
        wr(OFF_CTRL1, 8'h80);
        chkB(adcPowerDown, 1'b1);
        evStart(3'h0, t);
        chk(32'(t), 32'd40);
        $display("ignored trigger test done");
        end_sim();
    end
endmodule // atl_top_tb
